/* hdl/oda_core.sv */
// Decode, issue accounting and execute for the addition path
//
// Behaviour
// - Top six bits form opcode, low half
// - Logic and shift immediate opcode assignments
// - Memory access opcode assignments
// - Conditional branch opcode assignments
// - Compare immediate opcode assignments
// - Opcode 0D adds sign-extended immediate
// - Register add sums two source registers
// - Issue count equals entry cycles occupied
// - Branches issue four, stall three cycles
// - Result figure counts cycles until usable
// - Debug control register held at zero
// - Zero register always reads zero
// - Add zero into zero is nop
// - Or upper shifts immediate by sixteen
// - Equiv with zero register gives complement
// - Jump to return link returns
// - Register format fields, low bits zero
`timescale 1ns/1ps
`default_nettype none
module oda_core
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Instruction fetch handshake
    input  wire logic        i_instr_valid,
    input  wire logic [31:0] i_instr_word,
    output logic             o_instr_ready,
    // Writeback result
    output logic             o_wb_valid,
    output logic      [4:0]  o_wb_dest,
    output logic      [31:0] o_wb_data,
    // Control transfer
    output logic             o_jump_valid,
    output logic      [31:0] o_jump_target,
    // Decode status
    output logic             o_illegal,
    output logic             o_unsupported,
    output logic      [2:0]  o_issue_cost,
    output logic      [2:0]  o_result_latency,
    output logic      [31:0] o_debug_ctrl,
    output logic             o_debug_remap_enable
);

    typedef struct packed {
        logic [1:0]  stall_cnt;
        logic        wb_valid;
        logic [4:0]  wb_dest;
        logic [31:0] wb_data;
        logic        jump_valid;
        logic [31:0] jump_target;
        logic        illegal;
        logic        unsupported;
        logic [2:0]  issue_cost;
        logic [2:0]  result_lat;
    } oda_state_t;

    oda_state_t st_r;
    oda_state_t st_nxt;

    oda_pkg::oda_class_t dec_class;
    logic [2:0]          dec_issue;
    logic                dec_illegal;
    logic [5:0]          opc;
    logic                rr_fmt;
    logic [4:0]          src_a_field;
    logic [4:0]          src_b_field;
    logic [4:0]          dest_reg_field;
    logic [15:0]         immediate_field;
    logic [31:0]         opnd_a;
    logic [31:0]         opnd_b;
    logic                take;
    logic                wr_en;
    logic                nop_word;

    function automatic logic [31:0] sext16(input logic [15:0] v);
        sext16 = {{16{v[15]}}, v};
    endfunction : sext16

    function automatic logic [31:0] add32(input logic [31:0] a, input logic [31:0] b);
        add32 = a + b;
    endfunction : add32

    oda_decode u_decode
    (
        .i_word    (i_instr_word),
        .o_class   (dec_class),
        .o_issue   (dec_issue),
        .o_illegal (dec_illegal)
    );

    assign opc    = i_instr_word[oda_pkg::OPC_HI:oda_pkg::OPC_LO];
    assign rr_fmt = i_instr_word[oda_pkg::FMT_BIT];

    assign src_a_field     = i_instr_word[oda_pkg::SRC_A_HI:oda_pkg::SRC_A_LO];
    assign immediate_field = i_instr_word[oda_pkg::IMM_HI:oda_pkg::IMM_LO];
    assign src_b_field     = i_instr_word[oda_pkg::SRC_B_HI:oda_pkg::SRC_B_LO];
    assign dest_reg_field  = rr_fmt ? i_instr_word[oda_pkg::RDST_HI:oda_pkg::RDST_LO]
                                    : i_instr_word[oda_pkg::IDST_HI:oda_pkg::IDST_LO];

    assign o_instr_ready = (st_r.stall_cnt == 2'h0);
    assign take          = i_instr_valid && o_instr_ready;

    assign nop_word = (opc == oda_pkg::OP_ADD_IMM)
                      && (src_a_field == oda_pkg::ZERO_REGISTER)
                      && (dest_reg_field == oda_pkg::ZERO_REGISTER)
                      && (immediate_field == 16'h0000);

    assign wr_en = take && !nop_word
                   && (dec_class == oda_pkg::CLS_ADD
                       || (dec_class == oda_pkg::CLS_LOGIC
                           && (opc == oda_pkg::OP_OR_UPPER_IMM
                               || (rr_fmt && opc == oda_pkg::OP_EQUIV_REG))));

    oda_regfile u_regfile
    (
        .i_sys_clk  (i_sys_clk),
        .i_rst      (i_rst),
        .i_rd_a_sel (src_a_field),
        .i_rd_b_sel (src_b_field),
        .o_rd_a     (opnd_a),
        .o_rd_b     (opnd_b),
        .i_wr_en    (wr_en),
        .i_wr_sel   (dest_reg_field),
        .i_wr_data  (st_nxt.wb_data)
    );

    always_comb
    begin
        st_nxt            = st_r;
        st_nxt.wb_valid   = 1'b0;
        st_nxt.jump_valid = 1'b0;
        if (st_r.stall_cnt != 2'h0)
            st_nxt.stall_cnt = st_r.stall_cnt - 2'h1;
        if (take)
        begin
            st_nxt.illegal     = dec_illegal;
            st_nxt.unsupported = 1'b0;
            st_nxt.issue_cost  = dec_issue;
            st_nxt.result_lat  = oda_pkg::RESULT_ONE;
            if (dec_issue == oda_pkg::ISSUE_BRANCH)
                st_nxt.stall_cnt = 2'(oda_pkg::ISSUE_BRANCH - oda_pkg::ISSUE_SINGLE);
            st_nxt.wb_dest = dest_reg_field;
            st_nxt.wb_data = 32'h0000_0000;
            if (rr_fmt && opc == oda_pkg::OP_ADD_REG && dec_class == oda_pkg::CLS_ADD)
                st_nxt.wb_data = add32(opnd_a, opnd_b);
            else if (opc == oda_pkg::OP_ADD_IMM)
                st_nxt.wb_data = add32(opnd_a, sext16(immediate_field));
            else if (opc == oda_pkg::OP_OR_UPPER_IMM)
                st_nxt.wb_data = opnd_a | {immediate_field, 16'h0000};
            else if (rr_fmt && opc == oda_pkg::OP_EQUIV_REG)
                st_nxt.wb_data = ~(opnd_a ^ opnd_b);
            st_nxt.wb_valid = wr_en;
            if (dec_class == oda_pkg::CLS_JUMP)
            begin
                st_nxt.jump_valid  = 1'b1;
                st_nxt.jump_target = opnd_a;
            end
            st_nxt.unsupported = !dec_illegal && !wr_en && !nop_word
                                 && dec_class != oda_pkg::CLS_JUMP;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign o_wb_valid       = st_r.wb_valid;
    assign o_wb_dest        = st_r.wb_dest;
    assign o_wb_data        = st_r.wb_data;
    assign o_jump_valid     = st_r.jump_valid;
    assign o_jump_target    = st_r.jump_target;
    assign o_illegal        = st_r.illegal;
    assign o_unsupported    = st_r.unsupported;
    assign o_issue_cost     = st_r.issue_cost;
    assign o_result_latency = st_r.result_lat;

    assign o_debug_ctrl         = oda_pkg::DEBUG_CTRL_RESET;
    assign o_debug_remap_enable = oda_pkg::DEBUG_CTRL_RESET[oda_pkg::DEBUG_REMAP_BIT];

endmodule : oda_core
`default_nettype wire

/* hdl/oda_decode.sv */
// Combinational opcode classifier
`timescale 1ns/1ps
`default_nettype none
module oda_decode
(
    // Instruction word
    input  wire logic [31:0]        i_word,
    // Decoded class and issue cost
    output var oda_pkg::oda_class_t o_class,
    output logic       [2:0]        o_issue,
    output logic                    o_illegal
);

    logic [5:0] opc;
    assign opc = i_word[oda_pkg::OPC_HI:oda_pkg::OPC_LO];

    always_comb
    begin
        o_class = oda_pkg::CLS_ILLEGAL;
        if (!opc[5])
        begin
            unique case (opc)
                oda_pkg::OP_NOR_IMM, oda_pkg::OP_XOR_IMM, oda_pkg::OP_AND_IMM,
                oda_pkg::OP_EQUIV_IMM, oda_pkg::OP_OR_IMM,
                oda_pkg::OP_AND_UPPER_IMM, oda_pkg::OP_OR_UPPER_IMM:
                    o_class = oda_pkg::CLS_LOGIC;
                oda_pkg::OP_SHIFT_RIGHT_LOGICAL_IMM, oda_pkg::OP_SHIFT_RIGHT_ARITH_IMM,
                oda_pkg::OP_SHIFT_LEFT_IMM:
                    o_class = oda_pkg::CLS_SHIFT;
                oda_pkg::OP_MULTIPLY_IMM:
                    o_class = oda_pkg::CLS_MUL;
                oda_pkg::OP_LOAD_BYTE_SIGNED, oda_pkg::OP_LOAD_HALF_SIGNED,
                oda_pkg::OP_LOAD_WORD, oda_pkg::OP_LOAD_HALF_UNSIGNED,
                oda_pkg::OP_LOAD_BYTE_UNSIGNED:
                    o_class = oda_pkg::CLS_LOAD;
                oda_pkg::OP_STORE_HALFWORD, oda_pkg::OP_STORE_BYTE,
                oda_pkg::OP_STORE_WORD:
                    o_class = oda_pkg::CLS_STORE;
                oda_pkg::OP_JUMP_IF_EQUAL, oda_pkg::OP_JUMP_IF_GREATER,
                oda_pkg::OP_JUMP_IF_GE, oda_pkg::OP_JUMP_IF_GE_UNSIGNED,
                oda_pkg::OP_JUMP_IF_GT_UNSIGNED, oda_pkg::OP_JUMP_IF_NOT_EQUAL:
                    o_class = oda_pkg::CLS_BRANCH;
                oda_pkg::OP_COMPARE_EQ_IMM, oda_pkg::OP_COMPARE_GT_IMM,
                oda_pkg::OP_COMPARE_GE_IMM, oda_pkg::OP_COMPARE_GE_UNSIGNED_IMM,
                oda_pkg::OP_COMPARE_GT_UNSIGNED_IMM, oda_pkg::OP_COMPARE_NE_IMM:
                    o_class = oda_pkg::CLS_COMPARE;
                oda_pkg::OP_ADD_IMM:
                    o_class = oda_pkg::CLS_ADD;
                default:
                    o_class = oda_pkg::CLS_ILLEGAL;
            endcase
        end
        else if (i_word[oda_pkg::RR_ZERO_HI:0] == 11'h000)
        begin
            if (opc == oda_pkg::OP_ADD_REG)
                o_class = oda_pkg::CLS_ADD;
            else if (opc == oda_pkg::OP_EQUIV_REG)
                o_class = oda_pkg::CLS_LOGIC;
        end
        if (opc == oda_pkg::OP_JUMP_TO_REGISTER
            && i_word[oda_pkg::SRC_B_HI:0] == 21'h000000)
            o_class = oda_pkg::CLS_JUMP;
    end

    assign o_illegal = (o_class == oda_pkg::CLS_ILLEGAL);
    assign o_issue = (o_class == oda_pkg::CLS_BRANCH || o_class == oda_pkg::CLS_JUMP)
                     ? oda_pkg::ISSUE_BRANCH : oda_pkg::ISSUE_SINGLE;

endmodule : oda_decode
`default_nettype wire

/* hdl/oda_regfile.sv */
// General-purpose register file with hardwired zero register
`timescale 1ns/1ps
`default_nettype none
module oda_regfile
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Read ports
    input  wire logic [4:0]  i_rd_a_sel,
    input  wire logic [4:0]  i_rd_b_sel,
    output logic      [31:0] o_rd_a,
    output logic      [31:0] o_rd_b,
    // Write port
    input  wire logic        i_wr_en,
    input  wire logic [4:0]  i_wr_sel,
    input  wire logic [31:0] i_wr_data
);

    typedef struct packed {
        logic [31:0][31:0] gpr;
    } oda_rf_state_t;

    oda_rf_state_t st_r;
    oda_rf_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (i_wr_en)
            st_nxt.gpr[i_wr_sel] = i_wr_data;
        st_nxt.gpr[oda_pkg::ZERO_REGISTER] = 32'h0000_0000;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign o_rd_a = (i_rd_a_sel == oda_pkg::ZERO_REGISTER) ? 32'h0000_0000 : st_r.gpr[i_rd_a_sel];
    assign o_rd_b = (i_rd_b_sel == oda_pkg::ZERO_REGISTER) ? 32'h0000_0000 : st_r.gpr[i_rd_b_sel];

endmodule : oda_regfile
`default_nettype wire

/* shared/oda_pkg.sv */
// Opcode map, field layout and timing constants for the decode and add path
package oda_pkg;

    // Instruction word fields
    localparam int OPC_HI      = 31;
    localparam int OPC_LO      = 26;
    localparam int FMT_BIT     = 31;
    localparam int SRC_A_HI    = 25;
    localparam int SRC_A_LO    = 21;
    localparam int SRC_B_HI    = 20;
    localparam int SRC_B_LO    = 16;
    localparam int IDST_HI     = 20;
    localparam int IDST_LO     = 16;
    localparam int RDST_HI     = 15;
    localparam int RDST_LO     = 11;
    localparam int IMM_HI      = 15;
    localparam int IMM_LO      = 0;
    localparam int RR_ZERO_HI  = 10;
    localparam int UPPER_SHIFT = 16;

    // Immediate-format primary opcodes
    localparam logic [5:0] OP_SHIFT_RIGHT_LOGICAL_IMM = 6'h00;
    localparam logic [5:0] OP_NOR_IMM                 = 6'h01;
    localparam logic [5:0] OP_MULTIPLY_IMM            = 6'h02;
    localparam logic [5:0] OP_STORE_HALFWORD          = 6'h03;
    localparam logic [5:0] OP_LOAD_BYTE_SIGNED        = 6'h04;
    localparam logic [5:0] OP_SHIFT_RIGHT_ARITH_IMM   = 6'h05;
    localparam logic [5:0] OP_XOR_IMM                 = 6'h06;
    localparam logic [5:0] OP_LOAD_HALF_SIGNED        = 6'h07;
    localparam logic [5:0] OP_AND_IMM                 = 6'h08;
    localparam logic [5:0] OP_EQUIV_IMM               = 6'h09;
    localparam logic [5:0] OP_LOAD_WORD               = 6'h0A;
    localparam logic [5:0] OP_LOAD_HALF_UNSIGNED      = 6'h0B;
    localparam logic [5:0] OP_STORE_BYTE              = 6'h0C;
    localparam logic [5:0] OP_ADD_IMM                 = 6'h0D;
    localparam logic [5:0] OP_OR_IMM                  = 6'h0E;
    localparam logic [5:0] OP_SHIFT_LEFT_IMM          = 6'h0F;
    localparam logic [5:0] OP_LOAD_BYTE_UNSIGNED      = 6'h10;
    localparam logic [5:0] OP_JUMP_IF_EQUAL           = 6'h11;
    localparam logic [5:0] OP_JUMP_IF_GREATER         = 6'h12;
    localparam logic [5:0] OP_JUMP_IF_GE              = 6'h13;
    localparam logic [5:0] OP_JUMP_IF_GE_UNSIGNED     = 6'h14;
    localparam logic [5:0] OP_JUMP_IF_GT_UNSIGNED     = 6'h15;
    localparam logic [5:0] OP_STORE_WORD              = 6'h16;
    localparam logic [5:0] OP_JUMP_IF_NOT_EQUAL       = 6'h17;
    localparam logic [5:0] OP_AND_UPPER_IMM           = 6'h18;
    localparam logic [5:0] OP_COMPARE_EQ_IMM          = 6'h19;
    localparam logic [5:0] OP_COMPARE_GT_IMM          = 6'h1A;
    localparam logic [5:0] OP_COMPARE_GE_IMM          = 6'h1B;
    localparam logic [5:0] OP_COMPARE_GE_UNSIGNED_IMM = 6'h1C;
    localparam logic [5:0] OP_COMPARE_GT_UNSIGNED_IMM = 6'h1D;
    localparam logic [5:0] OP_OR_UPPER_IMM            = 6'h1E;
    localparam logic [5:0] OP_COMPARE_NE_IMM          = 6'h1F;

    // Register-format codes that this path executes
    localparam logic [5:0] OP_ADD_REG          = 6'h2D;
    localparam logic [5:0] OP_EQUIV_REG        = 6'h29;
    localparam logic [5:0] OP_JUMP_TO_REGISTER = 6'h30;

    // Register numbers
    localparam logic [4:0] ZERO_REGISTER   = 5'h00;
    localparam logic [4:0] RETURN_LINK_REG = 5'h1D;

    // Issue and result accounting
    localparam logic [2:0] ISSUE_SINGLE = 3'h1;
    localparam logic [2:0] ISSUE_BRANCH = 3'h4;
    localparam logic [2:0] RESULT_ONE   = 3'h1;

    // Debug control register, held at zero
    localparam logic [31:0] DEBUG_CTRL_RESET = 32'h0000_0000;
    localparam int          DEBUG_REMAP_BIT  = 1;

    // Operation classes
    typedef enum logic [3:0] {
        CLS_NONE,
        CLS_ADD,
        CLS_LOGIC,
        CLS_SHIFT,
        CLS_MUL,
        CLS_LOAD,
        CLS_STORE,
        CLS_BRANCH,
        CLS_COMPARE,
        CLS_JUMP,
        CLS_ILLEGAL
    } oda_class_t;

endpackage : oda_pkg

/* verif/oda_core_assertions.sv */
// Port-level checker for the decode and add path
`timescale 1ns/1ps
`default_nettype none
module oda_core_assertions
(
    // Clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    // Fetch handshake
    input wire logic        i_instr_valid,
    input wire logic [31:0] i_instr_word,
    input wire logic        o_instr_ready,
    // Results and status
    input wire logic        o_wb_valid,
    input wire logic [4:0]  o_wb_dest,
    input wire logic [31:0] o_wb_data,
    input wire logic        o_jump_valid,
    input wire logic        o_illegal,
    input wire logic        o_unsupported,
    input wire logic [2:0]  o_issue_cost,
    input wire logic [2:0]  o_result_latency,
    input wire logic [31:0] o_debug_ctrl,
    input wire logic        o_debug_remap_enable
);
    logic        take;
    logic [5:0]  opc;
    logic [4:0]  sa;
    logic [4:0]  di;
    logic        jmp;
    logic        brn;
    logic        ill;
    logic [31:0] pw;
    assign take = i_instr_valid && o_instr_ready;
    assign opc  = i_instr_word[31:26];
    assign sa   = i_instr_word[25:21];
    assign di   = i_instr_word[20:16];
    assign jmp  = opc == 6'h30 && i_instr_word[20:0] == 21'h0;
    assign brn  = jmp || opc inside {6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h17};
    assign ill  = i_instr_word[31] && !jmp
                  && !(opc inside {6'h29, 6'h2D} && i_instr_word[10:0] == 11'h0);
    // Word of the previous edge
    always_ff @(posedge i_sys_clk)
        pw <= i_instr_word;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    imm_add_a: assert property (take && opc == 6'h0D && sa == 5'h0 && di != 5'h0
        |=> o_wb_valid && o_wb_dest == pw[20:16] && o_wb_data == {{16{pw[15]}}, pw[15:0]})
        else $error("immediate add result wrong");
    upper_load_a: assert property (take && opc == 6'h1E && sa == 5'h0 && di != 5'h0
        |=> o_wb_valid && o_wb_data == {pw[15:0], 16'h0000})
        else $error("upper immediate load wrong");
    reg_add_a: assert property (take && opc == 6'h2D && !ill && i_instr_word[15:11] != 5'h0
        |=> o_wb_valid && o_wb_dest == pw[15:11])
        else $error("register add destination wrong");
    branch_stall_a: assert property (take && brn
        |=> !o_instr_ready [*3] ##1 o_instr_ready)
        else $error("branch stall length wrong");
    branch_cost_a: assert property (take && brn |=> o_issue_cost == 3'h4)
        else $error("branch issue cost wrong");
    single_issue_a: assert property (take && !brn && !ill
        |=> o_instr_ready && o_issue_cost == 3'h1)
        else $error("single issue not back to back");
    illegal_flag_a: assert property (take && ill |=> o_illegal && !o_wb_valid)
        else $error("illegal word not flagged");
    imm_unsup_a: assert property (take && !i_instr_word[31] && !(opc inside {6'h0D, 6'h1E})
        |=> o_unsupported && !o_wb_valid && !o_illegal)
        else $error("immediate code decoded wrongly");
    nop_quiet_a: assert property (take && i_instr_word == 32'h3400_0000
        |=> !o_wb_valid && !o_unsupported && !o_illegal)
        else $error("nop had an effect");
    result_one_a: assert property (take && !ill |=> o_result_latency == 3'h1)
        else $error("result latency wrong");
    jump_pulse_a: assert property (take && jmp |=> o_jump_valid ##1 !o_jump_valid)
        else $error("jump pulse wrong");
    debug_zero_a: assert property (o_debug_ctrl == 32'h0 && !o_debug_remap_enable)
        else $error("debug control not zero");
endmodule : oda_core_assertions
`default_nettype wire

/* verif/oda_fetch_model.sv */
// Fetch partner: offers queued words, holds each until taken
`timescale 1ns/1ps
`default_nettype none
module oda_fetch_model
(
    // Clock
    input  wire logic        i_sys_clk,
    // Handshake
    input  wire logic        i_ready,
    output logic             o_valid,
    output logic      [31:0] o_word
);
    logic [31:0] q [$];
    bit          slow = 1'b0;
    initial
    begin
        o_valid = 1'b0;
        o_word  = 32'h0;
    end
    task automatic push(input logic [31:0] w);
        q.push_back(w);
    endtask : push
    // Hold word until taken, scramble idle bus
    always @(posedge i_sys_clk)
    begin
        if (!o_valid || i_ready)
        begin
            if (q.size() != 0 && !(slow && $urandom_range(1, 0) == 0))
            begin
                o_valid <= 1'b1;
                o_word  <= q.pop_front();
            end
            else
            begin
                o_valid <= 1'b0;
                o_word  <= ~o_word;
            end
        end
    end
endmodule : oda_fetch_model
`default_nettype wire

/* verif/opcode_decode_add_path_tb.sv */
// Self-checking bench for the decode and add path
`timescale 1ns/1ps
`default_nettype none
module opcode_decode_add_path_tb;
    typedef struct packed {
        logic        wb;
        logic [4:0]  dst;
        logic [31:0] dat;
        logic        jmp;
        logic        ill;
        logic        uns;
        logic [2:0]  iss;
    } oda_exp_t;
    logic        i_sys_clk;
    logic        i_rst;
    logic        i_instr_valid;
    logic [31:0] i_instr_word;
    logic        o_instr_ready;
    logic        o_wb_valid;
    logic [4:0]  o_wb_dest;
    logic [31:0] o_wb_data;
    logic        o_jump_valid;
    logic [31:0] o_jump_target;
    logic        o_illegal;
    logic        o_unsupported;
    logic [2:0]  o_issue_cost;
    logic [2:0]  o_result_latency;
    logic [31:0] o_debug_ctrl;
    logic        o_debug_remap_enable;
    logic [31:0] rf [32];
    oda_exp_t    exp_q [$];
    logic        tk_r = 1'b0;
    int          fails = 0;
    int          total_checks = 0;
    int          cycles = 0;
    oda_core dut_u
    (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
        .i_instr_word(i_instr_word), .o_instr_ready(o_instr_ready), .o_wb_valid(o_wb_valid),
        .o_wb_dest(o_wb_dest), .o_wb_data(o_wb_data), .o_jump_valid(o_jump_valid),
        .o_jump_target(o_jump_target), .o_illegal(o_illegal), .o_unsupported(o_unsupported),
        .o_issue_cost(o_issue_cost), .o_result_latency(o_result_latency),
        .o_debug_ctrl(o_debug_ctrl), .o_debug_remap_enable(o_debug_remap_enable)
    );
    oda_fetch_model fetch_u
    (
        .i_sys_clk(i_sys_clk), .i_ready(o_instr_ready), .o_valid(i_instr_valid),
        .o_word(i_instr_word)
    );
    function automatic logic [31:0] imw(input logic [5:0] op, input logic [4:0] a,
                                        input logic [4:0] d, input logic [15:0] i);
        return {op, a, d, i};
    endfunction : imw
    function automatic logic [31:0] rrw(input logic [5:0] op, input logic [4:0] a,
                                        input logic [4:0] b, input logic [4:0] d);
        return {op, a, b, d, 11'h000};
    endfunction : rrw
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] want, input string what);
        total_checks++;
        if (got !== want)
        begin
            fails++;
            $display("BAD %0t %s got %h want %h", $time, what, got, want);
        end
    endtask : cmp
    // Predict outcome, then hand word to fetch
    task automatic send(input logic [31:0] w);
        oda_exp_t    e;
        logic [5:0]  op;
        logic [31:0] a;
        logic [31:0] b;
        op = w[31:26];
        a = rf[w[25:21]];
        b = rf[w[20:16]];
        e = '0;
        e.iss = 3'h1;
        if (!w[31])
        begin
            e.dst = w[20:16];
            e.wb = op == 6'h0D || op == 6'h1E;
            e.uns = !e.wb;
            e.dat = op == 6'h0D ? a + {{16{w[15]}}, w[15:0]} : a | {w[15:0], 16'h0000};
            if (op inside {6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h17})
                e.iss = 3'h4;
        end
        else if (op inside {6'h29, 6'h2D} && w[10:0] == 11'h0)
        begin
            e.wb = 1'b1;
            e.dst = w[15:11];
            e.dat = op == 6'h2D ? a + b : ~(a ^ b);
        end
        else if (op == 6'h30 && w[20:0] == 21'h0)
        begin
            e.jmp = 1'b1;
            e.dat = a;
            e.iss = 3'h4;
        end
        else
            e.ill = 1'b1;
        if (e.dst == 5'h00)
            e.wb = 1'b0;
        if (e.wb)
            rf[e.dst] = e.dat;
        exp_q.push_back(e);
        fetch_u.push(w);
    endtask : send
    task automatic check(input oda_exp_t e);
        cmp(o_wb_valid, e.wb, "wb valid");
        if (e.wb)
        begin
            cmp(o_wb_dest, e.dst, "wb dest");
            cmp(o_wb_data, e.dat, "wb data");
        end
        cmp(o_jump_valid, e.jmp, "jump valid");
        if (e.jmp)
            cmp(o_jump_target, e.dat, "jump target");
        cmp(o_illegal, e.ill, "illegal");
        cmp(o_unsupported, e.uns, "unsupported");
        if (!e.ill)
        begin
            cmp(o_issue_cost, e.iss, "issue cost");
            cmp(o_result_latency, 3'h1, "latency");
        end
        cmp(o_debug_ctrl, 32'h0, "debug ctrl");
        cmp(o_debug_remap_enable, 1'b0, "remap");
    endtask : check
    // Result watcher, one cycle after each take
    always @(posedge i_sys_clk)
    begin
        if (tk_r)
            check(exp_q.pop_front());
        else if (!i_rst)
            cmp(o_wb_valid | o_jump_valid, 1'b0, "stray pulse");
        tk_r <= !i_rst && i_instr_valid && o_instr_ready;
    end
    initial
    begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            stop_test();
        end
    end
    initial
    begin
        logic [31:0] r;
        foreach (rf[k])
            rf[k] = 32'h0;
        i_rst = 1'b1;
        void'($urandom(22591));
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        send(imw(6'h0D, 5'h00, 5'h03, 16'h0005));
        send(32'hB463_2000);
        send(imw(6'h0D, 5'h03, 5'h05, 16'hFFFE));
        send(32'h3400_0000);
        send(imw(6'h1E, 5'h00, 5'h06, 16'h1234));
        send(rrw(6'h29, 5'h06, 5'h00, 5'h07));
        send(rrw(6'h2D, 5'h00, 5'h00, 5'h09));
        for (int k = 0; k < 32; k++)
            send(imw(6'(k), 5'h03, 5'h08, 16'($urandom)));
        send(imw(6'h0D, 5'h00, 5'h1D, 16'h0100));
        send({6'h30, 5'h1D, 21'h0});
        send({6'h30, 5'h03, 21'h0});
        for (int k = 32; k < 64; k++)
            if (!(k inside {41, 45, 48}))
                send({6'(k), 26'($urandom)});
        send(rrw(6'h2D, 5'h01, 5'h02, 5'h0A) | 32'h1);
        send({6'h30, 5'h01, 21'h4});
        for (int p = 0; p < 2; p++)
        begin
            while (fetch_u.q.size() != 0)
                @(posedge i_sys_clk);
            fetch_u.slow = p[0];
            repeat (20)
            begin
                r = $urandom;
                send(r[0] ? imw(6'h0D, r[5:1], r[10:6] | 5'h01, r[31:16])
                          : rrw(6'h2D, r[5:1], r[15:11], r[10:6] | 5'h01));
            end
        end
        repeat (600)
            if (exp_q.size() != 0 || fetch_u.q.size() != 0)
                @(posedge i_sys_clk);
        repeat (3) @(posedge i_sys_clk);
        cmp(exp_q.size(), 32'h0, "pending results");
        stop_test();
    end
endmodule : opcode_decode_add_path_tb
bind oda_core oda_core_assertions chk_u
(
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
    .i_instr_word(i_instr_word), .o_instr_ready(o_instr_ready), .o_wb_valid(o_wb_valid),
    .o_wb_dest(o_wb_dest), .o_wb_data(o_wb_data), .o_jump_valid(o_jump_valid),
    .o_illegal(o_illegal), .o_unsupported(o_unsupported), .o_issue_cost(o_issue_cost),
    .o_result_latency(o_result_latency), .o_debug_ctrl(o_debug_ctrl),
    .o_debug_remap_enable(o_debug_remap_enable)
);
`default_nettype wire
